// file: design/ifsr_top.v
// Slave-side I2C readout port of a gas flow sensor.
// Assumes SCL and SDA arrive asynchronously from the pins through external pull-ups,
// the measurement logic offers 12-bit flow samples with valid/ready, and
// clk_sys_i is at least 20 times the bus bit rate.
// Operation
// R1: Acknowledge only slave address 0x50; ignore all others.
// R2: Work as slave at both 100 kHz and 400 kHz clock rates.
// R3: Master opens each transaction with SDA falling while SCL high.
// R4: Master closes each transaction with SDA rising while SCL high.
// R5: Eight data bits then one response bit; 0 acknowledges, 1 refuses.
// R6: After an acknowledge, another byte may follow or a stop.
// R7: Pull SDA low during response bit of a received byte, then release.
// R8: Master treats a missing acknowledge as not-acknowledge.
// R9: Flow count linear: 409 at zero flow, 3686 at full scale.
// R10: Lines are open drain; release to show high, never drive high.
// R11: Master sends 7-bit address then read bit 1 after start.
// R12: Read returns checksum first, then flow bytes, MSB first.
// R13: Flow is 12 bits; only low nibble of high byte valid.
// R14: Checksum is two's complement of modulo-256 sum of data bytes.
// R15: Master acknowledges each byte except the last, which it refuses.
`include "ifsr_defs.vh"
`timescale 1ns/10ps
module ifsr_top
#(
   parameter FLOW_W = 12,
   parameter FIFO_DEPTH = `IFSR_FIFO_DEPTH
)
(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe_o,
   output wire scl_o,
   output wire scl_oe_o,
   input wire flow_valid_i,
   output wire flow_ready_o,
   input wire [FLOW_W-1:0] flow_count_i,
   output reg [FLOW_W-1:0] flow_count_output_o,
   output reg busy_o,
   output reg read_done_o
);

   // ==================================================
   // State encoding
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_AACK = 5'h04;
   localparam [4:0] ST_SEND = 5'h08;
   localparam [4:0] ST_MACK = 5'h10;

   // ==================================================
   // Functions
   function [7:0] ifsr_checksum;
      input [11:0] flow;
      begin
         // R14 checksum negate
         ifsr_checksum = 8'h00 - ({`IFSR_FLOW_HI_PAD, flow[11:8]} + flow[7:0]);
      end
   endfunction

   function [7:0] ifsr_frame_byte;
      input [1:0] idx;
      input [11:0] flow;
      begin
         // R12 checksum then flow
         // R13 high nibble padded
         case (idx)
            2'h0: ifsr_frame_byte = ifsr_checksum(flow);
            2'h1: ifsr_frame_byte = {`IFSR_FLOW_HI_PAD, flow[11:8]};
            2'h2: ifsr_frame_byte = flow[7:0];
            default: ifsr_frame_byte = 8'hff;
         endcase
      end
   endfunction

   // ==================================================
   // Pin synchronisation
   wire [1:0] pins_sync;
   wire scl_s;
   wire sda_s;

   ifsr_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .async_i({scl_i, sda_i}),
      .sync_o(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   // ==================================================
   // Sample buffer
   wire fifo_out_valid;
   reg fifo_out_ready;
   wire [FLOW_W-1:0] fifo_out_data;

   ifsr_fifo #(
      .WIDTH(FLOW_W),
      .DEPTH(FIFO_DEPTH),
      .AW(2)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(flow_valid_i),
      .in_ready_o(flow_ready_o),
      .in_data_i(flow_count_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // ==================================================
   // Bus event detection
   reg scl_d;
   reg sda_d;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;

   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // R2 edge based, rate free
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   // R3 start detect
   assign start_det = scl_s && scl_d && sda_d && !sda_s;
   // R4 stop detect
   assign stop_det = scl_s && scl_d && !sda_d && sda_s;

   // ==================================================
   // Protocol engine
   reg [4:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg [1:0] byte_idx;
   reg [FLOW_W-1:0] snap;
   reg sda_low;
   reg mack_seen;
   wire [1:0] next_idx;
   wire [7:0] first_byte;
   wire [7:0] next_byte;

   // Frame index saturates, so bytes past the frame read as released
   assign next_idx = (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;
   assign first_byte = ifsr_frame_byte(2'h0, snap);
   assign next_byte = ifsr_frame_byte(next_idx, snap);

   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         byte_idx <= 2'h0;
         snap <= `IFSR_FLOW_ZERO;
         sda_low <= 1'b0;
         mack_seen <= 1'b0;
         fifo_out_ready <= 1'b0;
         flow_count_output_o <= `IFSR_FLOW_ZERO;
         busy_o <= 1'b0;
         read_done_o <= 1'b0;
      end
      else
      begin
         fifo_out_ready <= 1'b0;
         read_done_o <= 1'b0;
         // Keep latest sample when idle, so a read never waits on the sensor
         if (fifo_out_valid && !fifo_out_ready && (state == ST_IDLE))
         begin
            fifo_out_ready <= 1'b1;
            // R9 count passed on unscaled
            flow_count_output_o <= fifo_out_data;
         end
         if (stop_det)
         begin
            // R4 stop releases bus
            state <= ST_IDLE;
            sda_low <= 1'b0;
            busy_o <= 1'b0;
         end
         else if (start_det)
         begin
            // Repeated start also lands here
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
            busy_o <= 1'b1;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  sda_low <= 1'b0;
               end
               ST_ADDR:
               begin
                  // R5 sample on rising SCL
                  if (scl_rise)
                  begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && (bit_cnt == 4'h8))
                  begin
                     // R1 match address and read bit
                     // R11 read direction only
                     if ((shift[7:1] == `IFSR_SLAVE_ADDR) && shift[0])
                     begin
                        // R7 pull low for ack
                        sda_low <= 1'b1;
                        snap <= flow_count_output_o;
                        state <= ST_AACK;
                     end
                     else
                     begin
                        state <= ST_IDLE;
                        busy_o <= 1'b0;
                     end
                  end
               end
               ST_AACK:
               begin
                  if (scl_fall)
                  begin
                     // R10 load first bit; low only by pulling
                     byte_idx <= 2'h0;
                     shift <= first_byte;
                     sda_low <= !first_byte[7];
                     bit_cnt <= 4'h1;
                     state <= ST_SEND;
                  end
               end
               ST_SEND:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt == 4'h8)
                     begin
                        // R7 release for master response
                        sda_low <= 1'b0;
                        state <= ST_MACK;
                     end
                     else
                     begin
                        // R12 MSB first
                        shift <= {shift[6:0], 1'b1};
                        sda_low <= !shift[6];
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                     mack_seen <= !sda_s;
                  else if (scl_fall)
                  begin
                     // R8 release stays, R15 nack ends frame
                     if (mack_seen)
                     begin
                        // R6 next byte follows
                        byte_idx <= next_idx;
                        shift <= next_byte;
                        sda_low <= !next_byte[7];
                        bit_cnt <= 4'h1;
                        state <= ST_SEND;
                     end
                     else
                     begin
                        read_done_o <= 1'b1;
                        state <= ST_IDLE;
                     end
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
                  sda_low <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==================================================
   // Open-drain pins
   // R10 drive low only
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_low;
   // Clock stretching is never needed at this sample rate
   assign scl_o = 1'b0;
   assign scl_oe_o = 1'b0;

endmodule

// file: design/ifsr_defs.vh
// Constants for the flow sensor I2C slave readout port.
// Assumes nothing beyond plain Verilog-2005 inclusion.
`ifndef IFSR_DEFS_VH
`define IFSR_DEFS_VH

// ==================================================
// Bus address and flow scale
`define IFSR_SLAVE_ADDR 7'h50
`define IFSR_FLOW_ZERO 12'h199
`define IFSR_FLOW_FULL 12'he66
`define IFSR_FLOW_SPAN 12'hccd
`define IFSR_FLOW_MAX_LPM 8'hc8

// ==================================================
// Frame layout
`define IFSR_FLOW_HI_PAD 4'h0
`define IFSR_FRAME_BYTES 2
`define IFSR_FIFO_DEPTH 4

// ==================================================
// Timing: sync stages and sample rate
`define IFSR_SYNC_STAGES 2
`define IFSR_CLK_MHZ 10
`define IFSR_FAST_KHZ 400
`define IFSR_STD_KHZ 100

`endif

// file: design/ifsr_sync.v
// Two-flop synchroniser for the bus pins.
// Assumes the input is asynchronous to clk_sys_i.
`timescale 1ns/10ps
module ifsr_sync
#(
   parameter WIDTH = 2
)
(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   // Idle bus lines float high, so reset to ones
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage1 <= {WIDTH{1'b1}};
         stage2 <= {WIDTH{1'b1}};
      end
      else
      begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;

endmodule

// file: design/ifsr_fifo.v
// Small flop FIFO with valid/ready on both sides.
// Assumes a single clock; reading and writing in one cycle is allowed.
`timescale 1ns/10ps
module ifsr_fifo
#(
   parameter WIDTH = 12,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   integer i;

   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr];

   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

endmodule

// file: dv/ifsr_props.sv
// Checker for the flow sensor I2C readout port.
// Sees only ifsr_top pins; the bus lines are asynchronous.
`timescale 1ns/10ps
module ifsr_props_chk
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic flow_ready_o,
   input wire logic busy_o,
   input wire logic read_done_o
);
   // ====
   // Bus watch, same sync depth as the design
   logic [2:0] sc;
   logic [2:0] sd;
   logic [3:0] nbit;
   logic [7:0] sh;
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sc <= 3'h7;
         sd <= 3'h7;
         nbit <= 4'h9;
         sh <= 8'h00;
      end
      else
      begin
         sc <= {sc[1:0], scl_i};
         sd <= {sd[1:0], sda_i};
         if (sc[1] && sd[2] && !sd[1])
            nbit <= 4'h0;
         else if (sc[1] && !sc[2] && nbit < 4'h9)
         begin
            nbit <= nbit + 4'h1;
            sh <= (nbit < 4'h8) ? {sh[6:0], sd[1]} : sh;
         end
      end
   end
   // ====
   // Properties
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_start;
      sc[1] && sd[2] && !sd[1];
   endsequence
   sequence s_stop;
      sc[1] && !sd[2] && sd[1];
   endsequence
   sequence s_own_ack;
      sc[1] && !sc[2] && nbit == 4'h8 && sh == 8'ha1;
   endsequence
   a_sda_low_only: assert property (!sda_o)
      else $error("sda driven high");
   a_scl_released: assert property (!scl_oe_o && !scl_o)
      else $error("scl driven");
   a_idle_quiet: assert property (!busy_o |-> !sda_oe_o)
      else $error("sda pulled while idle");
   a_own_ack: assert property (s_own_ack |-> sda_oe_o)
      else $error("own address not acknowledged");
   a_other_ignored: assert property (nbit == 4'h8 && sh != 8'ha1 |-> !sda_oe_o)
      else $error("foreign address acknowledged");
   a_start_busy: assert property (s_start |-> ##[1:4] busy_o)
      else $error("start not seen");
   a_stop_idle: assert property (s_stop |-> ##[1:4] !busy_o)
      else $error("stop not seen");
   a_done_pulse: assert property (read_done_o |=> !read_done_o)
      else $error("done longer than one cycle");
   a_fifo_drains: assert property (!flow_ready_o && !busy_o |-> ##[1:8] flow_ready_o)
      else $error("buffer not drained when idle");
endmodule

bind ifsr_top ifsr_props_chk chk
(
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .flow_ready_o(flow_ready_o),
   .busy_o(busy_o), .read_done_o(read_done_o)
);

// file: dv/ifsr_master.sv
// Behavioural I2C bus master that reads the flow sensor port.
// Assumes pull-ups on both lines outside; it only ever pulls low.
`timescale 1ns/10ps
module ifsr_master
(
   input wire logic sda_i,
   output logic scl_oe_o = 1'b0,
   output logic sda_oe_o = 1'b0
);
   // Quarter bit time; 200 gives an 800 ns clock
   int q = 200;
   // ====
   // Bus conditions
   // start, address follows
   task start;
      sda_oe_o = 1'b1;
      #q scl_oe_o = 1'b1;
      #q;
   endtask
   task stop;
      sda_oe_o = 1'b1;
      #q scl_oe_o = 1'b0;
      #q sda_oe_o = 1'b0;
      #q;
   endtask
   // a one is a released line
   task bitx(input logic b, output logic r);
      sda_oe_o = !b;
      #q scl_oe_o = 1'b0;
      #q r = sda_i;
      #q scl_oe_o = 1'b1;
      #q;
   endtask
   // eight bits then response; a silent slave reads as one
   task xfer(input logic [7:0] d, input logic ak, output logic [7:0] v, output logic r);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], v[i]);
      bitx(ak, r);
   endtask
endmodule

// file: dv/ifsr_tb_top.sv
// Self-checking bench for the flow sensor I2C readout port.
// Samples go in directly, the bus runs through the master model with pull-ups.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module ifsr_tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic flow_valid_i = 1'b0;
   logic [11:0] flow_count_i = 12'h000;
   wire sda_o, sda_oe_o, scl_o, scl_oe_o, flow_ready_o, busy_o, read_done_o;
   wire [11:0] flow_count_output_o;
   wire m_scl_oe, m_sda_oe;
   // Open drain: low while anyone pulls
   wire scl = !(m_scl_oe || scl_oe_o);
   wire sda = !(m_sda_oe || sda_oe_o);
   int err_total = 0;
   int checks = 0;
   int dn = 0;
   logic [7:0] bad [3] = '{8'ha3, 8'ha0, 8'h21};
   always #50 clk_sys_i = !clk_sys_i;
   always @(posedge clk_sys_i)
      if (read_done_o === 1'b1)
         dn++;
   ifsr_top uut
   (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .flow_valid_i(flow_valid_i),
      .flow_ready_o(flow_ready_o), .flow_count_i(flow_count_i),
      .flow_count_output_o(flow_count_output_o), .busy_o(busy_o), .read_done_o(read_done_o)
   );
   ifsr_master m (.sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
   // ====
   // Helpers
   task results;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task push(input logic [11:0] v);
      @(posedge clk_sys_i);
      #1 flow_valid_i = 1'b1;
      flow_count_i = v;
      @(posedge clk_sys_i);
      #1 flow_valid_i = 1'b0;
   endtask
   task wt(input logic [11:0] f);
      repeat (20)
         if (flow_count_output_o !== f)
         begin
            @(posedge clk_sys_i);
            #1;
         end
      `CHK(flow_count_output_o, f)
      if (flow_count_output_o !== f)
         results;
   endtask
   task rd(input logic [11:0] f, input logic fill);
      logic [7:0] cs, hi, lo, x;
      logic a;
      int n;
      int d0;
      n = 0;
      d0 = dn;
      push(f);
      repeat (5) @(posedge clk_sys_i);
      wt(f);
      // Bus edges land just after a clock edge, like every other input
      @(posedge clk_sys_i);
      #1 m.start;
      m.xfer(8'ha1, 1'b1, x, a);
      `CHK(a, 1'b0)
      // Bus held busy, so the buffer must not drain
      while (fill && n < 6 && flow_ready_o === 1'b1)
      begin
         push(12'h200 + 12'(n));
         n++;
      end
      m.xfer(8'hff, 1'b0, cs, a);
      m.xfer(8'hff, 1'b0, hi, a);
      m.xfer(8'hff, !fill, lo, a);
      if (fill)
         m.xfer(8'hff, 1'b1, x, a);
      m.stop;
      repeat (4) @(posedge clk_sys_i);
      `CHK(hi, {4'h0, f[11:8]})
      `CHK(lo, f[7:0])
      `CHK(cs, 8'h00 - {4'h0, f[11:8]} - f[7:0])
      `CHK(x, fill ? 8'hff : 8'ha1)
      `CHK(n, fill ? 4 : 0)
      `CHK(busy_o, 1'b0)
      `CHK(dn, d0 + 1)
   endtask
   // ====
   // Scenarios
   task t_reset;
      `CHK(flow_count_output_o, 12'h199)
      `CHK(sda_oe_o, 1'b0)
      `CHK(busy_o, 1'b0)
      $display("reset test ends");
   endtask
   task t_read(input logic [11:0] f);
      rd(f, 1'b0);
      $display("read test %h ends", f);
   endtask
   task t_other;
      logic [7:0] x;
      logic a;
      @(posedge clk_sys_i);
      #1;
      for (int i = 0; i < 3; i++)
      begin
         m.start;
         m.xfer(bad[i], 1'b1, x, a);
         `CHK(a, 1'b1)
         m.xfer(8'hff, 1'b1, x, a);
         `CHK(x, 8'hff)
         m.stop;
      end
      $display("foreign address test ends");
   endtask
   task t_fifo;
      rd(12'h5a3, 1'b1);
      wt(12'h203);
      `CHK(flow_ready_o, 1'b1)
      $display("buffer test ends");
   endtask
   task t_burst;
      int k;
      int stall;
      k = 0;
      stall = 0;
      @(posedge clk_sys_i);
      #1 flow_valid_i = 1'b1;
      // Each word stays until the edge that takes it; idle drain is slower than this
      for (int j = 0; j < 40 && k < 8; j++)
      begin
         flow_count_i = 12'h300 + 12'(k);
         if (flow_ready_o === 1'b1)
            k++;
         else
            stall++;
         @(posedge clk_sys_i);
         #1;
      end
      flow_valid_i = 1'b0;
      `CHK(k, 8)
      `CHK(stall > 0, 1'b1)
      wt(12'h307);
      `CHK(flow_ready_o, 1'b1)
      $display("burst test ends");
   endtask
   initial
   begin
      #2000000;
      err_total++;
      results;
   end
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      #1 rst_n_i = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      t_reset;
      t_read(12'h199);
      t_read(12'he66);
      m.q = 2500;
      t_read(12'h5a3);
      m.q = 200;
      t_other;
      t_fifo;
      t_burst;
      results;
   end
endmodule
